// [include/nmc_pkg.sv]
// package for the nested memory type combiner and execute trap block
package nmc_pkg;

  // ==========================================================================
  // memory type encodings (page attribute encodings, plus internal types)
  // ==========================================================================
  typedef enum logic [3:0]
  {
    MT_UC       = 4'h0,
    MT_WC       = 4'h1,
    MT_WT       = 4'h4,
    MT_WP       = 4'h5,
    MT_WB       = 4'h6,
    MT_UCM      = 4'h7,
    MT_CD       = 4'h8,
    MT_WCP      = 4'h9
  } nmc_mtype_type;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [11:0] REG_CTRL_OFS   = 12'h000;
  localparam logic [11:0] REG_GUEST_ATTRIBUTE_TABLE_LO    = 12'h004;
  localparam logic [11:0] REG_GUEST_ATTRIBUTE_TABLE_HI    = 12'h008;
  localparam logic [11:0] REG_HPAT_LO    = 12'h00C;
  localparam logic [11:0] REG_HPAT_HI    = 12'h010;
  localparam logic [11:0] REG_STATUS_OFS = 12'h014;
  localparam logic [11:0] REG_RESULT_OFS = 12'h018;
  localparam logic [11:0] REG_FAULT_OFS  = 12'h01C;
  localparam logic [11:0] REG_FEAT_OFS   = 12'h020;
  localparam logic [11:0] REG_CTLBLK_OFS = 12'h024;

  // ctrl field positions
  localparam int CTRL_NP_EN   = 0;
  localparam int CTRL_GCD     = 1;
  localparam int CTRL_HCD     = 2;
  localparam int CTRL_GPTR_WT = 3;
  localparam int CTRL_GPTR_CD = 4;
  localparam int CTRL_NPTR_WT = 5;
  localparam int CTRL_NPTR_CD = 6;
  localparam int CTRL_EPA     = 7;

  // guest control block word: execute trap enable bit 3 of offset 090h
  localparam logic [11:0] CTLBLK_TRAP_OFS = 12'h090;
  localparam int          CTLBLK_TRAP_BIT = 3;

  // feature query: bit 17 of the fourth output register
  localparam int FEAT_TRAP_BIT = 17;

  // fault code bits
  localparam int FC_PRESENT = 0;
  localparam int FC_WRITE   = 1;
  localparam int FC_USER    = 2;
  localparam int FC_RSV     = 3;
  localparam int FC_FETCH   = 4;

  // reset values (power-on attribute table layout)
  localparam logic [63:0] PAT_RST  = 64'h0007040600070406;
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // cycles a combiner drain pulse stays high
  localparam int DRAIN_CYCLES = 1;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed
  {
    logic       page_cache_disable;
    logic       page_write_through;
    logic       attribute_index_bit;
    logic [2:0] size;   // log2 page size class, 0 = smallest
    logic       nx;
    logic       us;
    logic       present;
    logic       rsv;
  } nmc_pte_type;

  typedef struct packed
  {
    logic       valid;
    logic [3:0] mtype;
    logic [2:0] size;
    logic       fault;
    logic [4:0] fcode;
  } nmc_result_type;

endpackage : nmc_pkg

// [src/nmc_core.sv]
// nested memory type combine, splintering, on-demand pointer_directory_entry and execute trap
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
// ============================================================================
// ============================================================================
module nmc_core
  import nmc_pkg::*;
(
  input  wire logic           I_CLK_SYS,
  input  wire logic           I_NRST,
  input  wire logic           I_CE,
  // apb slave
  input  wire logic           I_PSEL,
  input  wire logic           I_PENABLE,
  input  wire logic           I_PWRITE,
  input  wire logic [11:0]    I_PADDR,
  input  wire logic [31:0]    I_PWDATA,
  output logic      [31:0]    O_PRDATA,
  output logic                O_PREADY,
  output logic                O_PSLVERR,
  // translation request from the walker
  input  wire logic           I_REQ_VALID,
  input  wire nmc_pte_type    I_GUEST_PTE,
  input  wire nmc_pte_type    I_NEST_PTE,
  input  wire logic [2:0]     I_RANGE_TYPE,
  input  wire logic [51:0]    I_SYS_PADDR,
  input  wire logic           I_FETCH,
  input  wire logic           I_WRITE,
  input  wire logic [1:0]     I_CPL,
  // pointer directory fetch during walk
  input  wire logic           I_POINTER_DIRECTORY_ENTRY_VALID,
  input  wire logic [63:0]    I_POINTER_DIRECTORY_ENTRY_DATA,
  // world switches
  input  wire logic           I_WORLD_ENTRY,
  input  wire logic           I_WORLD_EXIT,
  output logic                O_RESULT_VALID,
  output nmc_result_type      O_RESULT,
  output logic                O_SNOOP_ALL,
  output logic                O_COMBINE,
  output logic                O_DRAIN_WC,
  output logic                O_POINTER_DIRECTORY_ENTRY_FAULT,
  output logic      [51:0]    O_RANGE_ADDR
);

  // ==========================================================================
  // functions
  // ==========================================================================
  function automatic logic [3:0] pat_lookup(input logic [63:0] page_attribute_table, input logic [2:0] idx);
    logic [7:0] f;
    f = page_attribute_table[idx*8 +: 8];
    pat_lookup = {1'b0, f[2:0]};
  endfunction : pat_lookup

  function automatic logic [2:0] pat_index(input logic attribute_index_bit, input logic page_cache_disable, input logic page_write_through,
                                           input logic bcd, input logic bwt);
    pat_index = {attribute_index_bit, page_cache_disable | bcd, page_write_through | bwt};
  endfunction : pat_index

  // guest row, host column order uc ucm wc wp wt wb
  function automatic logic [3:0] merge_gh(input logic [3:0] g, input logic [3:0] h);
    merge_gh = MT_UC;
    case (g)
      MT_UC, MT_UCM: merge_gh = MT_UC;
      MT_WC:         merge_gh = (h == MT_UC || h == MT_UCM || h == MT_WC) ? MT_WC : MT_WCP;
      MT_WP:         merge_gh = (h == MT_WP || h == MT_WB) ? MT_WP : MT_UC;
      MT_WT:         merge_gh = (h == MT_WT || h == MT_WB) ? MT_WT : MT_UC;
      MT_WB:         merge_gh = (h == MT_UCM) ? MT_UC : h;
      default:       merge_gh = MT_UC;
    endcase
  endfunction : merge_gh

  function automatic logic [3:0] merge_range(input logic [3:0] p, input logic [3:0] m);
    merge_range = MT_UC;
    case (p)
      MT_UC:  merge_range = m;
      MT_UCM: merge_range = (m == MT_UC || m == MT_WC) ? m : MT_CD;
      MT_WC:  merge_range = MT_WC;
      MT_WCP: merge_range = (m == MT_UC) ? MT_WC : MT_WCP;
      MT_WP:  merge_range = (m == MT_UC) ? MT_UC : (m == MT_WP || m == MT_WB) ? MT_WP : MT_CD;
      MT_WT:  merge_range = (m == MT_UC) ? MT_UC : (m == MT_WT || m == MT_WB) ? MT_WT : MT_CD;
      MT_WB:  merge_range = m;
      default: merge_range = MT_UC;
    endcase
  endfunction : merge_range

  // ==========================================================================
  // registers
  // ==========================================================================
  logic [7:0]      ctrl_r;
  logic [63:0]     guest_attribute_table_r;
  logic [63:0]     hpat_r;
  logic            trap_en_r;
  logic            trap_arm_r;
  logic [31:0]     prdata_r;
  logic            pready_r;
  logic            pslverr_r;
  logic            res_valid_r;
  nmc_result_type  res_r;
  logic            snoop_r;
  logic            comb_r;
  logic            drain_r;
  logic            pointer_directory_entry_fault_r;
  logic [51:0]     range_addr_r;
  logic [7:0]      fault_cnt_r;

  wire logic acc = I_PSEL && I_PENABLE && !pready_r;
  wire logic wr  = acc && I_PWRITE;
  wire logic hit = (I_PADDR <= REG_CTLBLK_OFS) && (I_PADDR[1:0] == 2'b00);

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
    begin
      ctrl_r <= CTRL_RST;
      guest_attribute_table_r <= PAT_RST;
      hpat_r <= PAT_RST;
      trap_arm_r <= 1'b0;
    end
    else if (I_CE && wr)
    begin
      case (I_PADDR)
        REG_CTRL_OFS:   ctrl_r <= I_PWDATA[7:0];
        // guest attribute writes land in the host copy when nested is off
        REG_GUEST_ATTRIBUTE_TABLE_LO:    if (ctrl_r[CTRL_NP_EN]) guest_attribute_table_r[31:0] <= I_PWDATA;
                        else hpat_r[31:0] <= I_PWDATA;
        REG_GUEST_ATTRIBUTE_TABLE_HI:    if (ctrl_r[CTRL_NP_EN]) guest_attribute_table_r[63:32] <= I_PWDATA;
                        else hpat_r[63:32] <= I_PWDATA;
        REG_HPAT_LO:    hpat_r[31:0] <= I_PWDATA;
        REG_HPAT_HI:    hpat_r[63:32] <= I_PWDATA;
        REG_CTLBLK_OFS: trap_arm_r <= I_PWDATA[CTLBLK_TRAP_BIT];
        default:        ;
      endcase
    end
  end

  // trap mode latched at world entry only
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
      trap_en_r <= 1'b0;
    else if (I_CE && I_WORLD_ENTRY)
      trap_en_r <= trap_arm_r;
  end

  // ==========================================================================
  // apb answer: one wait cycle, pready registered
  // ==========================================================================
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
    begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (I_CE)
    begin
      pready_r  <= acc;
      pslverr_r <= acc && !hit;
      prdata_r  <= 32'h0;
      if (acc && !I_PWRITE)
      begin
        case (I_PADDR)
          REG_CTRL_OFS:   prdata_r <= {24'h0, ctrl_r};
          REG_GUEST_ATTRIBUTE_TABLE_LO:    prdata_r <= guest_attribute_table_r[31:0];
          REG_GUEST_ATTRIBUTE_TABLE_HI:    prdata_r <= guest_attribute_table_r[63:32];
          REG_HPAT_LO:    prdata_r <= hpat_r[31:0];
          REG_HPAT_HI:    prdata_r <= hpat_r[63:32];
          REG_STATUS_OFS: prdata_r <= {22'h0, fault_cnt_r, pointer_directory_entry_fault_r, trap_en_r};
          REG_RESULT_OFS: prdata_r <= {18'h0, res_r};
          REG_FAULT_OFS:  prdata_r <= {27'h0, res_r.fcode};
          REG_FEAT_OFS:   prdata_r <= 32'h1 << FEAT_TRAP_BIT;
          REG_CTLBLK_OFS: prdata_r <= {28'h0, trap_arm_r, 3'h0};
          default:        prdata_r <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================================
  // translation combine
  // ==========================================================================
  logic [3:0] g_type;
  logic [3:0] h_type;
  logic [3:0] p_type;
  logic [3:0] f_type;
  logic       exec_ok;
  logic       fault;
  logic [4:0] fcode;

  always_comb
  begin
    h_type = pat_lookup(hpat_r, pat_index(I_NEST_PTE.attribute_index_bit, I_NEST_PTE.page_cache_disable, I_NEST_PTE.page_write_through,
                        ctrl_r[CTRL_NPTR_CD], ctrl_r[CTRL_NPTR_WT]));
    g_type = pat_lookup(guest_attribute_table_r, pat_index(I_GUEST_PTE.attribute_index_bit, I_GUEST_PTE.page_cache_disable, I_GUEST_PTE.page_write_through,
                        ctrl_r[CTRL_GPTR_CD], ctrl_r[CTRL_GPTR_WT]));
    if (ctrl_r[CTRL_NP_EN])
      p_type = merge_gh(g_type, h_type);
    else
      p_type = h_type;
    f_type = merge_range(p_type, {1'b0, I_RANGE_TYPE});
    if ((ctrl_r[CTRL_GCD] || ctrl_r[CTRL_HCD]) && f_type != MT_WCP && f_type != MT_WC)
      f_type = MT_CD;
    // no-execute wins, then trap for supervisor fetch of user pages
    exec_ok = !I_NEST_PTE.nx;
    if (trap_en_r && I_NEST_PTE.us && I_CPL != 2'd3)
      exec_ok = 1'b0;
    fault = !I_NEST_PTE.present || I_NEST_PTE.rsv || (I_FETCH && !exec_ok);
    fcode = '0;
    fcode[FC_PRESENT] = I_NEST_PTE.present;
    fcode[FC_WRITE]   = I_WRITE;
    fcode[FC_USER]    = 1'b1;
    fcode[FC_RSV]     = I_NEST_PTE.rsv;
    fcode[FC_FETCH]   = I_FETCH;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
    begin
      res_valid_r  <= 1'b0;
      res_r        <= '0;
      snoop_r      <= 1'b0;
      comb_r       <= 1'b0;
      range_addr_r <= '0;
    end
    else if (I_CE)
    begin
      res_valid_r  <= I_REQ_VALID;
      range_addr_r <= I_SYS_PADDR;
      if (I_REQ_VALID)
      begin
        res_r.valid <= 1'b1;
        res_r.mtype <= f_type;
        res_r.size  <= (I_GUEST_PTE.size < I_NEST_PTE.size) ?
                       I_GUEST_PTE.size : I_NEST_PTE.size;
        res_r.fault <= fault;
        res_r.fcode <= fcode;
        snoop_r     <= (f_type == MT_WCP) || (f_type == MT_CD);
        comb_r      <= (f_type == MT_WCP) || (f_type == MT_WC);
      end
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
      fault_cnt_r <= 8'h0;
    else if (I_CE && I_REQ_VALID && fault)
      fault_cnt_r <= fault_cnt_r + 8'h1;
  end

  // drain pulse on either world switch
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
      drain_r <= 1'b0;
    else if (I_CE)
      drain_r <= I_WORLD_ENTRY || I_WORLD_EXIT;
  end

  // pointer entries checked when fetched, never at base write
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
      pointer_directory_entry_fault_r <= 1'b0;
    else if (I_CE)
      pointer_directory_entry_fault_r <= I_POINTER_DIRECTORY_ENTRY_VALID && ctrl_r[CTRL_EPA] && I_POINTER_DIRECTORY_ENTRY_DATA[0] &&
                      (I_POINTER_DIRECTORY_ENTRY_DATA[2:1] != 2'b00 || I_POINTER_DIRECTORY_ENTRY_DATA[8:5] != 4'h0);
  end

  assign O_PRDATA       = prdata_r;
  assign O_PREADY       = pready_r;
  assign O_PSLVERR      = pslverr_r;
  assign O_RESULT_VALID = res_valid_r;
  assign O_RESULT       = res_r;
  assign O_SNOOP_ALL    = snoop_r;
  assign O_COMBINE      = comb_r;
  assign O_DRAIN_WC     = drain_r;
  assign O_POINTER_DIRECTORY_ENTRY_FAULT   = pointer_directory_entry_fault_r;
  assign O_RANGE_ADDR   = range_addr_r;

  // ==========================================================================
  // assertions
  // ==========================================================================
  sequence s_switch;
    I_CE && (I_WORLD_ENTRY || I_WORLD_EXIT);
  endsequence

  sequence s_quiet;
    I_CE && !I_WORLD_ENTRY && !I_WORLD_EXIT;
  endsequence

  sequence s_req;
    I_CE && I_REQ_VALID;
  endsequence

  AST_DRAIN: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    s_switch |=> O_DRAIN_WC) else $error("drain missing after switch");
  AST_NX: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && I_REQ_VALID && I_FETCH && I_NEST_PTE.nx) |=> O_RESULT.fault)
    else $error("nx fetch not faulted");
  AST_TRAP: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && I_REQ_VALID && I_FETCH && trap_en_r && I_NEST_PTE.us && I_CPL == 2'd0)
    |=> O_RESULT.fault) else $error("trap fault missing");
  AST_USER_OK: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && I_REQ_VALID && I_NEST_PTE.present && !I_NEST_PTE.rsv && !I_NEST_PTE.nx
     && !I_NEST_PTE.us) |=> !O_RESULT.fault) else $error("legal fetch faulted");
  AST_SIZE: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && I_REQ_VALID) |=> (O_RESULT.size == $past(I_GUEST_PTE.size) ||
    O_RESULT.size == $past(I_NEST_PTE.size)) && O_RESULT.size <= $past(I_GUEST_PTE.size) &&
    O_RESULT.size <= $past(I_NEST_PTE.size)) else $error("size not the smaller");
  AST_SNOOP: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    O_RESULT_VALID && O_RESULT.mtype == MT_WCP |-> O_SNOOP_ALL && O_COMBINE)
    else $error("wc+ not snooping");
  AST_NOCACHE: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && I_REQ_VALID && (ctrl_r[CTRL_GCD] || ctrl_r[CTRL_HCD])) |=>
    O_RESULT.mtype inside {MT_CD, MT_WC, MT_WCP}) else $error("cache not disabled");
  AST_FCODE: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && I_REQ_VALID && !I_NEST_PTE.present) |=> !O_RESULT.fcode[FC_PRESENT])
    else $error("present bit wrong");
  AST_APB: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && acc) |=> O_PREADY ##1 !O_PREADY) else $error("apb ready shape");

  // ==========================================================================
  // result, drain and pointer entry checks
  // ==========================================================================
  AST_DRAIN_ONE: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    s_quiet |=> !O_DRAIN_WC) else $error("drain longer than one cycle");
  AST_TRAP_SUP: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    s_req ##0 (I_FETCH && trap_en_r && I_NEST_PTE.us && I_CPL inside {2'd1, 2'd2})
    |=> O_RESULT.fault) else $error("trap fault missing at middle levels");
  AST_USER_FETCH: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    s_req ##0 (I_FETCH && I_CPL == 2'd3 && I_NEST_PTE.present && !I_NEST_PTE.rsv &&
    !I_NEST_PTE.nx) |=> !O_RESULT.fault) else $error("user fetch faulted");
  AST_FETCH_BIT: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    s_req ##0 (I_FETCH && !I_WRITE) |=> O_RESULT.fcode[FC_FETCH] &&
    !O_RESULT.fcode[FC_WRITE]) else $error("fault code access bits wrong");
  AST_WCP_UNCACHED: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    s_req ##0 (p_type == MT_WCP) |=> O_RESULT.mtype inside {MT_WC, MT_WCP, MT_CD})
    else $error("snooping combine became cacheable");
  AST_RANGE_ADDR: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_CE |=> O_RANGE_ADDR == $past(I_SYS_PADDR)) else $error("range address altered");
  AST_POINTER_DIRECTORY_ENTRY_AT_FETCH: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && I_POINTER_DIRECTORY_ENTRY_VALID && ctrl_r[CTRL_EPA] && I_POINTER_DIRECTORY_ENTRY_DATA[0] &&
    I_POINTER_DIRECTORY_ENTRY_DATA[2:1] != 2'b00) |=> O_POINTER_DIRECTORY_ENTRY_FAULT) else $error("bad pointer entry missed");
  AST_POINTER_DIRECTORY_ENTRY_QUIET: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_CE && !I_POINTER_DIRECTORY_ENTRY_VALID) |=> !O_POINTER_DIRECTORY_ENTRY_FAULT) else $error("pointer fault without fetch");

endmodule : nmc_core

// [verification/nmc_walker_model.sv]
// walker side model: translation requests, pointer entries, world switches
`timescale 1ns/10ps
module nmc_walker_model
  import nmc_pkg::*;
(
  input  wire logic         i_clk,
  output logic              o_req_valid,
  output nmc_pte_type       o_guest_pte,
  output nmc_pte_type       o_nest_pte,
  output logic [2:0]        o_range_type,
  output logic [51:0]       o_sys_paddr,
  output logic              o_fetch,
  output logic              o_write,
  output logic [1:0]        o_cpl,
  output logic              o_pointer_directory_entry_valid,
  output logic [63:0]       o_pointer_directory_entry_data,
  output logic              o_world_entry,
  output logic              o_world_exit
);
  // ==========================================================================
  // idle levels
  // ==========================================================================
  initial
  begin
    {o_req_valid, o_guest_pte, o_nest_pte, o_range_type, o_sys_paddr} = '0;
    {o_fetch, o_write, o_cpl, o_pointer_directory_entry_valid, o_pointer_directory_entry_data} = '0;
    {o_world_entry, o_world_exit} = '0;
  end

  // ==========================================================================
  // requests; released pte and address lines flip so stale data never looks valid
  // ==========================================================================
  task automatic xlate(input nmc_pte_type g, input nmc_pte_type n, input logic [2:0] rt,
                       input logic [51:0] pa, input logic f, input logic w,
                       input logic [1:0] c);
    @(posedge i_clk);
    o_req_valid  <= 1'b1;
    o_guest_pte  <= g;
    o_nest_pte   <= n;
    o_range_type <= rt;
    o_sys_paddr  <= pa;
    o_fetch      <= f;
    o_write      <= w;
    o_cpl        <= c;
    @(posedge i_clk);
    o_req_valid  <= 1'b0;
    o_guest_pte  <= ~g;
    o_nest_pte   <= ~n;
    o_sys_paddr  <= ~pa;
  endtask : xlate

  // entry handed over only when the walk reaches it
  task automatic pointer_directory_entry(input logic [63:0] d);
    @(posedge i_clk);
    o_pointer_directory_entry_valid <= 1'b1;
    o_pointer_directory_entry_data  <= d;
    @(posedge i_clk);
    o_pointer_directory_entry_valid <= 1'b0;
    o_pointer_directory_entry_data  <= ~d;
  endtask : pointer_directory_entry

  task automatic sw(input logic entry);
    @(posedge i_clk);
    o_world_entry <= entry;
    o_world_exit  <= ~entry;
    @(posedge i_clk);
    o_world_entry <= 1'b0;
    o_world_exit  <= 1'b0;
  endtask : sw
endmodule : nmc_walker_model

// [verification/nmc_core_tb.sv]
// self-checking bench for the nested memory type combiner
`timescale 1ns/10ps
module nmc_core_tb
  import nmc_pkg::*;
;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic           clk = 1'b0;
  logic           nrst = 1'b0;
  logic           ce = 1'b1;
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]    paddr = '0;
  logic [31:0]    pwdata = '0, prdata, rd;
  logic           pready, pslverr, er, req_v, fetch, wr, pointer_directory_entry_v, w_en, w_ex;
  logic           res_v, snoop, comb, drain, pointer_directory_entry_f;
  nmc_pte_type    gpte, npte;
  logic [2:0]     rtype;
  logic [51:0]    spa, raddr;
  logic [1:0]     current_privilege_level;
  logic [63:0]    pointer_directory_entry_d;
  nmc_result_type res;
  int             n_fail = 0, checked = 0, cyc = 0, seed = 55692, n_flt = 0;
  nmc_mtype_type  tl [6] = '{MT_UC, MT_WC, MT_WT, MT_WP, MT_WB, MT_UCM};
  nmc_mtype_type  rl [5] = '{MT_UC, MT_WC, MT_WP, MT_WT, MT_WB};

  nmc_core nmc_core_inst (.I_CLK_SYS(clk), .I_NRST(nrst), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_REQ_VALID(req_v),
    .I_GUEST_PTE(gpte), .I_NEST_PTE(npte), .I_RANGE_TYPE(rtype), .I_SYS_PADDR(spa),
    .I_FETCH(fetch), .I_WRITE(wr), .I_CPL(current_privilege_level), .I_POINTER_DIRECTORY_ENTRY_VALID(pointer_directory_entry_v),
    .I_POINTER_DIRECTORY_ENTRY_DATA(pointer_directory_entry_d), .I_WORLD_ENTRY(w_en), .I_WORLD_EXIT(w_ex),
    .O_RESULT_VALID(res_v), .O_RESULT(res), .O_SNOOP_ALL(snoop), .O_COMBINE(comb),
    .O_DRAIN_WC(drain), .O_POINTER_DIRECTORY_ENTRY_FAULT(pointer_directory_entry_f), .O_RANGE_ADDR(raddr));

  nmc_walker_model nmc_walker_model_inst (.i_clk(clk), .o_req_valid(req_v),
    .o_guest_pte(gpte), .o_nest_pte(npte), .o_range_type(rtype), .o_sys_paddr(spa),
    .o_fetch(fetch), .o_write(wr), .o_cpl(current_privilege_level), .o_pointer_directory_entry_valid(pointer_directory_entry_v),
    .o_pointer_directory_entry_data(pointer_directory_entry_d), .o_world_entry(w_en), .o_world_exit(w_ex));

  // ==========================================================================
  // clock, timeout, report
  // ==========================================================================
  always #2.5 clk = ~clk;

  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // a full run needs about 1200 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  // ==========================================================================
  // apb master: waits for pready, no fixed latency assumed
  // ==========================================================================
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // ==========================================================================
  // expected types
  // ==========================================================================
  function automatic nmc_mtype_type gh(nmc_mtype_type g, nmc_mtype_type h);
    case (g)
      MT_WC: return (h inside {MT_UC, MT_UCM, MT_WC}) ? MT_WC : MT_WCP;
      MT_WP: return (h inside {MT_WP, MT_WB}) ? MT_WP : MT_UC;
      MT_WT: return (h inside {MT_WT, MT_WB}) ? MT_WT : MT_UC;
      MT_WB: return (h == MT_UCM) ? MT_UC : h;
      default: return MT_UC;
    endcase
  endfunction : gh

  function automatic nmc_mtype_type mr(nmc_mtype_type c, nmc_mtype_type r);
    case (c)
      MT_UCM: return (r inside {MT_UC, MT_WC}) ? r : MT_CD;
      MT_WC: return MT_WC;
      MT_WCP: return (r == MT_UC) ? MT_WC : MT_WCP;
      MT_WP: return (r == MT_UC) ? MT_UC : (r inside {MT_WP, MT_WB}) ? MT_WP : MT_CD;
      MT_WT: return (r == MT_UC) ? MT_UC : (r inside {MT_WT, MT_WB}) ? MT_WT : MT_CD;
      default: return r;
    endcase
  endfunction : mr

  task automatic xreq(input int g, input int h, input int k, input int p);
    nmc_pte_type   gp, np;
    logic [51:0]   pa;
    logic          f, w, flt;
    logic [1:0]    c;
    nmc_mtype_type e;
    gp = 10'($random(seed));
    np = 10'($random(seed));
    {gp.attribute_index_bit, gp.page_cache_disable, gp.page_write_through, gp.nx, gp.us, gp.present, gp.rsv} = {3'(g), 4'h6};
    {np.attribute_index_bit, np.page_cache_disable, np.page_write_through, np.present, np.rsv} = {3'(h), 2'b10};
    pa = 52'({$random(seed), $random(seed)}) | 52'h0000000100000;
    {f, w, c} = 4'($random(seed));
    nmc_walker_model_inst.xlate(gp, np, rl[k][2:0], pa, f, w, c);
    #1;
    e = mr(gh(tl[g], tl[h]), rl[k]);
    if (p > 0 && e != MT_WC && e != MT_WCP)
      e = MT_CD;
    flt = f & (np.nx | (p == 2 && np.us && c != 2'd3));
    n_flt += flt;
    chk(res_v, 1'b1, "valid");
    chk(res.mtype, e, "mtype");
    chk(res.size, (gp.size < np.size) ? gp.size : np.size, "size");
    chk(res.fault, flt, "fault");
    if (flt)
      chk(res.fcode, {f, 1'b0, 1'b1, w, 1'b1}, "fault code");
    chk(raddr, pa, "range addr");
    if (e == MT_WCP)
      chk({snoop, comb}, 2'b11, "snoop combine");
    chk({snoop, comb}, {e == MT_WCP || e == MT_CD, e == MT_WCP || e == MT_WC}, "snoop");
  endtask : xreq

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, REG_CTRL_OFS, '0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, REG_HPAT_LO, '0);
    chk(rd, PAT_RST[31:0], "host table reset");
    apb(1'b0, REG_FEAT_OFS, '0);
    chk(rd[FEAT_TRAP_BIT], 1'b1, "feature bit");
    apb(1'b0, 12'h0FC, '0);
    chk({er, rd}, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, REG_GUEST_ATTRIBUTE_TABLE_LO, 32'h00010406);
    apb(1'b0, REG_HPAT_LO, '0);
    chk(rd, 32'h00010406, "guest write lands in host copy");
    $display("test registers done");
    apb(1'b1, REG_CTRL_OFS, 32'h1);
    for (int i = 0; i < 4; i++)
      apb(1'b1, REG_GUEST_ATTRIBUTE_TABLE_LO + 12'(4 * i), i[0] ? 32'h00000706 : 32'h05040100);
    for (int p = 0; p < 3; p++)
    begin
      apb(1'b1, REG_CTRL_OFS, 32'(1 + 2 * p));
      if (p == 2)
      begin
        apb(1'b1, REG_CTLBLK_OFS, 32'h8);
        nmc_walker_model_inst.sw(1'b1);
        #1;
        chk(drain, 1'b1, "drain on entry");
        @(posedge clk);
        #1;
        chk(drain, 1'b0, "drain one cycle");
      end
      for (int g = 0; g < 6; g++)
        for (int h = 0; h < 6; h++)
          for (int k = 0; k < 5; k++)
            xreq(g, h, k, p);
      $display("test merge pass %0d done", p);
    end
    nmc_walker_model_inst.sw(1'b0);
    #1;
    chk(drain, 1'b1, "drain on exit");
    apb(1'b1, REG_CTRL_OFS, 32'h81);
    nmc_walker_model_inst.pointer_directory_entry(64'h3);
    #1;
    chk(pointer_directory_entry_f, 1'b1, "bad pointer entry");
    nmc_walker_model_inst.pointer_directory_entry(64'h1);
    #1;
    chk(pointer_directory_entry_f, 1'b0, "good pointer entry");
    $display("test switches and pointer entries done");
    // clock enable low must freeze the fault flag
    @(posedge clk);
    ce <= 1'b0;
    nmc_walker_model_inst.pointer_directory_entry(64'h3);
    #1;
    chk(pointer_directory_entry_f, 1'b0, "frozen by clock enable");
    @(posedge clk);
    ce <= 1'b1;
    apb(1'b0, REG_STATUS_OFS, '0);
    chk(rd, {22'h0, 8'(n_flt), 1'b0, 1'b1}, "status");
    $display("test clock enable and status done");
    results();
  end
endmodule : nmc_core_tb
